// File: pin_chain_regs.vh
`ifndef PIN_CHAIN_REGS_VH
`define PIN_CHAIN_REGS_VH

// number of pins in the chain, output pin is entry 43
`define CHAIN_LEN 42
`define CHAIN_OUT_ENTRY 43
// strap code on {port2_indicator_b, port2_indicator_a, port4_indicator_a} selecting test mode
`define STRAP_CODE_W 3
`define STRAP_TEST_CODE 3'h5
// reset value of the latched mode
`define TEST_MODE_RST 1'h0

`endif

// File: pin_chain_nand_test.v
// Behaviour
// - in test mode, pins feed nested NAND chain; last gate drives irq_out_pin.
// - test mode chosen only by three indicator straps, never by a register.
// - all chain inputs high gives irq_out_pin high.
// - each next input pulled low in order toggles the output.
// - chain order fixed at 42 inputs starting with host_port_tx_bit7.
`include "pin_chain_regs.vh"
`default_nettype none

// one link of the nested chain; kept as its own module so that every link
// is the same two-input gate and nothing can be optimised into a wide gate
module nand_stage (
    // chain data
    input wire pin_level,
    input wire carry_in,

    // next link
    output wire carry_out
);

    assign carry_out = ~(pin_level & carry_in);

endmodule

module pin_chain_nand_test #(
    parameter CHAIN_LEN = `CHAIN_LEN
) (
    // clock and reset
    input wire mclk,
    input wire rst,

    // strap inputs, sampled after reset release
    input wire port2_indicator_b,
    input wire port2_indicator_a,
    input wire port4_indicator_a,

    // chain pin levels, index 0 is host_port_tx_bit7, then in sequence order
    input wire [CHAIN_LEN-1:0] chain_pins,

    // normal-function interrupt level from the device core
    input wire irq_normal,

    // pin outputs
    output wire irq_out_pin,
    output wire test_mode
);

    // strap latch states
    localparam [1:0] ST_STRAP = 2'h0;
    localparam [1:0] ST_NORMAL = 2'h1;
    localparam [1:0] ST_TEST = 2'h2;

    // an odd-length chain ends low with all pins high; one extra
    // inversion keeps the all-high result high for any length
    localparam ODD_LEN = CHAIN_LEN % 2;
    localparam [0:0] OUT_FLIP = ODD_LEN[0:0];

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg irq_out_ff;
    reg nxt_irq_out;
    reg test_mode_out_ff;

    wire [`STRAP_CODE_W-1:0] strap_code;
    wire strap_is_test;
    wire in_test;
    wire [CHAIN_LEN:0] carry;
    wire chain_out;

    genvar k;

    // strap decode
    assign strap_code = {port2_indicator_b, port2_indicator_a, port4_indicator_a};

    assign strap_is_test = (strap_code == `STRAP_TEST_CODE);

    assign in_test = (state_ff == ST_TEST);

    // straps are looked at once per reset; there is no register path,
    // so software can neither enter nor leave the mode
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_STRAP: begin
                if (strap_is_test) begin
                    nxt_state = ST_TEST;
                end else begin
                    nxt_state = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                nxt_state = ST_NORMAL;
            end
            ST_TEST: begin
                nxt_state = ST_TEST;
            end
            default: begin
                nxt_state = ST_STRAP;
            end
        endcase
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_STRAP;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // nested chain: link k = nand(pin k, link k-1), seeded high.
    // with all pins high the links alternate, so lowering the pins in
    // order flips the last link once per pin
    assign carry[0] = 1'b1;

    generate
        for (k = 0; k < CHAIN_LEN; k = k + 1) begin : g_link
            nand_stage u_stage (
                .pin_level(chain_pins[k]),
                .carry_in(carry[k]),
                .carry_out(carry[k+1])
            );
        end
    endgenerate

    assign chain_out = carry[CHAIN_LEN] ^ OUT_FLIP;

    // output selection: chain result in test mode, core interrupt otherwise
    always @* begin
        nxt_irq_out = irq_normal;
        if (in_test) begin
            nxt_irq_out = chain_out;
        end
    end

    // output is registered, which adds one mclk of latency that the
    // tester must allow for between lowering a pin and looking at it
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_out_ff <= 1'b1;
            test_mode_out_ff <= `TEST_MODE_RST;
        end else begin
            irq_out_ff <= nxt_irq_out;
            test_mode_out_ff <= in_test;
        end
    end

    assign irq_out_pin = irq_out_ff;
    assign test_mode = test_mode_out_ff;

endmodule

`default_nettype wire

// File: chain_chk_asserts.sv
`default_nettype none
module chain_chk #(parameter CHAIN_LEN = 42) (input wire logic mclk, rst, irq_normal,
    irq_out_pin, test_mode, input wire logic [CHAIN_LEN-1:0] chain_pins);
    timeunit 1ns; timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_hi; test_mode && &chain_pins |=> irq_out_pin; endproperty
    a_hi: assert property (p_hi) else $error("output low with all high");
    property p_tg; test_mode && $changed(chain_pins) |=> $changed(irq_out_pin); endproperty
    a_tg: assert property (p_tg) else $error("output did not toggle");
    property p_md; test_mode |=> test_mode; endproperty
    a_md: assert property (p_md) else $error("test mode lost");
    property p_nm; !test_mode ##1 !test_mode |-> irq_out_pin == $past(irq_normal); endproperty
    a_nm: assert property (p_nm) else $error("normal irq not passed");
    property p_st; test_mode && $stable(chain_pins) |=> $stable(irq_out_pin); endproperty
    a_st: assert property (p_st) else $error("output moved with pins still");
    property p_fs; test_mode && !chain_pins[0] && &chain_pins[CHAIN_LEN-1:1] |=> !irq_out_pin;
    endproperty
    a_fs: assert property (p_fs) else $error("first pin low did not drop output");
    c_md: cover property ($rose(test_mode));
    c_tg: cover property (test_mode && $fell(irq_out_pin));
    c_nm: cover property (!test_mode && $fell(irq_out_pin));
endmodule
`default_nettype wire

// File: chain_drv.sv
`default_nettype none
module chain_drv(input wire logic mclk, output logic [41:0] pins = '1);
    timeunit 1ns; timeprecision 1ns;
    // pins go low strictly in order and stay low, matching the board tester
    task automatic lower(int i);
        pins[i] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: pin_chain_nand_test_tb.sv
`default_nettype none
module pin_chain_nand_test_tb;
    timeunit 1ns; timeprecision 1ns;
    logic mclk = 0, rst = 1, irq_normal = 1, irq_out_pin, test_mode;
    logic [2:0] st = 3'h5;
    logic [41:0] pins;
    int mismatches = 0, checked = 0;
    pin_chain_nand_test dut(.mclk, .rst, .port2_indicator_b(st[2]), .port2_indicator_a(st[1]),
        .port4_indicator_a(st[0]), .chain_pins(pins), .irq_normal, .irq_out_pin, .test_mode);
    chain_drv drv(.mclk, .pins);
    task automatic check(logic seen, exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t saw %b want %b", $time, seen, exp);
        end
    endtask
    task automatic restart(logic [2:0] s);
        @(posedge mclk);
        rst <= 1;
        st <= s;
        repeat (5) @(posedge mclk);
        rst <= 0;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task automatic chain_walk;
        restart(3'h5);
        check(test_mode, 1);
        check(irq_out_pin, 1);
        for (int i = 0; i < 42; i++) begin
            @(posedge mclk);
            drv.lower(i);
            @(posedge mclk);
            #1 check(irq_out_pin, i[0]);
        end
    endtask
    task automatic normal_mode;
        restart(3'h4);
        @(posedge mclk);
        irq_normal <= 0;
        repeat (2) @(posedge mclk);
        #1 check(irq_out_pin, 0);
        check(test_mode, 0);
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial forever #20 mclk = ~mclk;
    initial begin
        chain_walk();
        normal_mode();
        tally_and_finish();
    end
    // walk and normal check take about 107 cycles
    initial begin
        #20000;
        mismatches++;
        tally_and_finish();
    end
endmodule
bind pin_chain_nand_test chain_chk #(.CHAIN_LEN(CHAIN_LEN)) chk(.*);
`default_nettype wire
